// >>> src/sbp_consts.svh
`ifndef SBP_CONSTS_SVH
`define SBP_CONSTS_SVH
// register indices; each register is one aligned word, so the byte
// address on the bus is four times the index
`define SBP_IDX_DIR       16'hffbd
`define SBP_IDX_LATCH     16'hffbf
`define SBP_IDX_CTRL      16'hffc0
`define SBP_IDX_STATUS    16'hffc1
// register byte addresses (apb paddr[17:0])
`define SBP_ADDR_DIR      {`SBP_IDX_DIR, 2'b00}
`define SBP_ADDR_LATCH    {`SBP_IDX_LATCH, 2'b00}
`define SBP_ADDR_CTRL     {`SBP_IDX_CTRL, 2'b00}
`define SBP_ADDR_STATUS   {`SBP_IDX_STATUS, 2'b00}
// reset values
`define SBP_DIR_RESET     8'h80
`define SBP_LATCH_RESET   8'h80
`define SBP_CTRL_RESET    9'h000
// reserved bit position and read-back of the write-only register
`define SBP_RSVD_BIT      7
`define SBP_WO_READ       8'hff
// control register fields
`define SBP_CTRL_TWE      0
`define SBP_CTRL_XCK      1
`define SBP_CTRL_SYN      2
`define SBP_CTRL_CKO      3
`define SBP_CTRL_SLV      4
`define SBP_CTRL_HPC      5
`define SBP_CTRL_REN      6
`define SBP_CTRL_IE5      7
`define SBP_CTRL_IE4      8
`define SBP_CTRL_W        9
// pin indices
`define SBP_PIN_CLK       6
`define SBP_PIN_RX        5
`endif

// >>> src/sbp_pkg.sv
package sbp_pkg;
   // function owning pin 6
   typedef enum logic [2:0] {
      SBP_P6_GPIO   = 3'h0,
      SBP_P6_TWCLK  = 3'h1,
      SBP_P6_SCKIN  = 3'h2,
      SBP_P6_SCKOUT = 3'h3
   } sbp_p6fn_t;
   // function owning pin 5
   typedef enum logic [2:0] {
      SBP_P5_GPIO  = 3'h0,
      SBP_P5_HSEL  = 3'h1,
      SBP_P5_RXIN  = 3'h2
   } sbp_p5fn_t;
endpackage : sbp_pkg

// >>> src/sbp_regfile.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbp_consts.svh"
// holds direction and output latch; cleared by reset or hardware standby
module sbp_regfile
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       hw_standby,
   input  wire logic       dir_we,
   input  wire logic       latch_we,
   input  wire logic [7:0] wdata,
   output var  logic [7:0] dir_q,
   output var  logic [7:0] latch_q
);
   // write-only direction register; bit 7 forced to one
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dir_q <= `SBP_DIR_RESET;
      else if (hw_standby)
         dir_q <= `SBP_DIR_RESET;
      else if (dir_we)
         dir_q <= {1'b1, wdata[6:0]};
   end
   // latch is written regardless of direction so a later switch drives it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         latch_q <= `SBP_LATCH_RESET;
      else if (hw_standby)
         latch_q <= `SBP_LATCH_RESET;
      else if (latch_we)
         latch_q <= {1'b1, wdata[6:0]};
   end
endmodule : sbp_regfile
`default_nettype wire

// >>> src/sbp_port.sv
// Behaviour
// - direction one drives pin, zero inputs
// - direction register reads all ones
// - bit seven reserved, always reads one
// - direction resets to 80 hex, standby too
// - software standby keeps direction and drive
// - latch bits six..zero drive output pins
// - output pins read back latch value
// - input pins read pin level
// - latch resets to 80 hex, soft standby keeps
// - two-wire enable gives pin six to bus clock
// - external clock select makes serial clock input
// - sync or clock enable outputs serial clock
// - pin six feeds interrupt line five
// - slave mode, control zero: host select input
// - receive enable makes pin five serial input
// - pin five feeds interrupt line four
//
`timescale 1ns/10ps
`default_nettype none
`include "sbp_consts.svh"
module sbp_port
   import sbp_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [17:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        hw_standby,
   input  wire logic        sw_standby,
   input  wire logic [6:0]  pin_in,
   output var  logic [6:0]  pin_out,
   output var  logic [6:0]  pin_oe,
   input  wire logic        sck_out,
   input  wire logic        twclk_out,
   input  wire logic        twclk_oe,
   output var  logic        twclk_in,
   output var  logic        sck_in,
   output var  logic        rx_in,
   output var  logic        host_sel_n,
   output var  logic        ext_ext_interrupt_line5_n,
   output var  logic        ext_ext_interrupt_line4_n
);
   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0]                dir_q;            // direction, bit7 = 1
   logic [7:0]                latch_q;          // output latch, bit7 = 1
   logic [`SBP_CTRL_W-1:0]    ctrl_r;           // mux controls from peers
   logic [`SBP_CTRL_W-1:0]    ctrl_nxt;         // next control value
   sbp_p6fn_t                 p6fn;             // pin 6 owner
   sbp_p5fn_t                 p5fn;             // pin 5 owner
   logic [6:0]                oe_nxt;           // next output enables
   logic [6:0]                out_nxt;          // next output values
   logic [7:0]                port_view;        // port read value
   logic [31:0]               rdata_nxt;        // decoded read data
   logic                      acc;              // access phase
   logic                      wr_dir;           // direction write strobe
   logic                      wr_latch;         // latch write strobe
   logic                      wr_ctrl;          // control write strobe
   logic                      hit;              // mapped address

   // decode helper: same address test used for several strobes; the full
   // byte address is compared, so no register shows up at an alias and a
   // stray access with low address bits set lands nowhere
   function automatic logic addr_is(input logic [17:0] a, input logic [17:0] r);
      addr_is = (a == r);
   endfunction : addr_is

   ////////////////////////////////////////////////////////////////////////
   // apb decode: zero-wait, always ready
   assign acc      = psel & penable;
   assign hit      = addr_is(paddr, `SBP_ADDR_DIR) | addr_is(paddr, `SBP_ADDR_LATCH)
                   | addr_is(paddr, `SBP_ADDR_CTRL) | addr_is(paddr, `SBP_ADDR_STATUS);
   assign wr_dir   = acc & pwrite & addr_is(paddr, `SBP_ADDR_DIR);
   assign wr_latch = acc & pwrite & addr_is(paddr, `SBP_ADDR_LATCH);
   assign wr_ctrl  = acc & pwrite & addr_is(paddr, `SBP_ADDR_CTRL);
   assign ctrl_nxt = wr_ctrl ? pwdata[`SBP_CTRL_W-1:0] : ctrl_r;

   // storage lives in its own module; software standby is not an input
   // there at all, so it never disturbs contents itself; bus writes still land during it
   sbp_regfile u_regs
   (
      .pclk       (pclk),
      .presetn    (presetn),
      .hw_standby (hw_standby),
      .dir_we     (wr_dir),
      .latch_we   (wr_latch),
      .wdata      (pwdata[7:0]),
      .dir_q      (dir_q),
      .latch_q    (latch_q)
   );

   // control register, cleared like the port registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_r <= `SBP_CTRL_RESET;
      else if (hw_standby)
         ctrl_r <= `SBP_CTRL_RESET;
      else
         ctrl_r <= ctrl_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // pin function selection
   assign p6fn = ctrl_r[`SBP_CTRL_TWE] ? SBP_P6_TWCLK :
                 ctrl_r[`SBP_CTRL_XCK] ? SBP_P6_SCKIN :
                 (ctrl_r[`SBP_CTRL_SYN] | ctrl_r[`SBP_CTRL_CKO]) ? SBP_P6_SCKOUT :
                 SBP_P6_GPIO;
   assign p5fn = (ctrl_r[`SBP_CTRL_SLV] & ~ctrl_r[`SBP_CTRL_HPC]) ? SBP_P5_HSEL :
                 ctrl_r[`SBP_CTRL_REN] ? SBP_P5_RXIN : SBP_P5_GPIO;

   // per-pin drive: gpio pins follow direction and latch
   always_comb
   begin
      oe_nxt  = dir_q[6:0];
      out_nxt = latch_q[6:0];
      case (p6fn)
         SBP_P6_TWCLK:
         begin
            oe_nxt[`SBP_PIN_CLK]  = twclk_oe;
            out_nxt[`SBP_PIN_CLK] = twclk_out;
         end
         SBP_P6_SCKIN:
         begin
            oe_nxt[`SBP_PIN_CLK]  = 1'b0;
            out_nxt[`SBP_PIN_CLK] = 1'b0;
         end
         SBP_P6_SCKOUT:
         begin
            oe_nxt[`SBP_PIN_CLK]  = 1'b1;
            out_nxt[`SBP_PIN_CLK] = sck_out;
         end
         default:
         begin
            oe_nxt[`SBP_PIN_CLK]  = dir_q[`SBP_PIN_CLK];
            out_nxt[`SBP_PIN_CLK] = latch_q[`SBP_PIN_CLK];
         end
      endcase
      case (p5fn)
         SBP_P5_HSEL, SBP_P5_RXIN:
         begin
            oe_nxt[`SBP_PIN_RX]  = 1'b0;
            out_nxt[`SBP_PIN_RX] = 1'b0;
         end
         default:
         begin
            oe_nxt[`SBP_PIN_RX]  = dir_q[`SBP_PIN_RX];
            out_nxt[`SBP_PIN_RX] = latch_q[`SBP_PIN_RX];
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // port read: output bits show latch, input bits the pin even when owned
   assign port_view = {1'b1, (latch_q[6:0] & dir_q[6:0]) | (pin_in & ~dir_q[6:0])};
   assign rdata_nxt = addr_is(paddr, `SBP_ADDR_DIR)    ? {24'h000000, `SBP_WO_READ} :
                      addr_is(paddr, `SBP_ADDR_LATCH)  ? {24'h000000, port_view} :
                      addr_is(paddr, `SBP_ADDR_CTRL)   ? {23'h000000, ctrl_r} :
                      addr_is(paddr, `SBP_ADDR_STATUS) ? {26'h0000000, p5fn[1:0], p6fn[1:0],
                                                          sw_standby, hw_standby} :
                      32'h00000000;

   ////////////////////////////////////////////////////////////////////////
   // registered outputs: bus answer and pins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata     <= 32'h00000000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         pin_oe     <= 7'h00;
         pin_out    <= 7'h00;
         twclk_in   <= 1'b1;
         sck_in     <= 1'b1;
         rx_in      <= 1'b1;
         host_sel_n <= 1'b1;
         ext_ext_interrupt_line5_n <= 1'b1;
         ext_ext_interrupt_line4_n <= 1'b1;
      end
      else
      begin
         // ready registered from the setup cycle, so it is high in the access phase, which ends at once
         pready     <= psel & ~penable;
         pslverr    <= psel & ~penable & ~hit;
         prdata     <= (psel & ~penable & ~pwrite) ? rdata_nxt : 32'h00000000;
         pin_oe     <= oe_nxt;
         pin_out    <= out_nxt;
         twclk_in   <= (p6fn == SBP_P6_TWCLK) ? pin_in[`SBP_PIN_CLK] : 1'b1;
         sck_in     <= (p6fn == SBP_P6_SCKIN) ? pin_in[`SBP_PIN_CLK] : 1'b1;
         rx_in      <= (p5fn == SBP_P5_RXIN)  ? pin_in[`SBP_PIN_RX]  : 1'b1;
         host_sel_n <= (p5fn == SBP_P5_HSEL)  ? pin_in[`SBP_PIN_RX]  : 1'b1;
         ext_ext_interrupt_line5_n <= ctrl_r[`SBP_CTRL_IE5]  ? pin_in[`SBP_PIN_CLK] : 1'b1;
         ext_ext_interrupt_line4_n <= ctrl_r[`SBP_CTRL_IE4]  ? pin_in[`SBP_PIN_RX]  : 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   // direction write at the access edge
   sequence dir_write_s;
      psel && penable && pwrite && paddr == `SBP_ADDR_DIR;
   endsequence
   // latch read request seen in the setup cycle
   sequence lat_read_s;
      psel && !penable && !pwrite && paddr == `SBP_ADDR_LATCH;
   endsequence
   // latch write at the access edge; hardware standby would override it
   sequence lat_write_s;
      psel && penable && pwrite && paddr == `SBP_ADDR_LATCH && !hw_standby;
   endsequence
   // both shared pins left to the direction and latch registers
   sequence gpio_pins_s;
      p6fn == SBP_P6_GPIO && p5fn == SBP_P5_GPIO;
   endsequence

   // write-only register answers all ones
   dir_read_ones_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == `SBP_ADDR_DIR |=> prdata[7:0] == 8'hff)
      else $error("direction read not all ones");
   // new direction reaches the output enables one cycle after it is stored
   dir_drives_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
      dir_write_s ##1 gpio_pins_s |=> pin_oe == $past(dir_q[6:0]))
      else $error("output enable does not follow direction");
   // reserved bit of both registers stays set
   rsvd_bit_one_a: assert property (@(posedge pclk) disable iff (!presetn)
      dir_q[7] && latch_q[7])
      else $error("reserved bit cleared");
   // hardware standby restores both registers every cycle it is held
   hw_standby_init_a: assert property (@(posedge pclk) disable iff (!presetn)
      hw_standby |=> dir_q == 8'h80 && latch_q == 8'h80)
      else $error("standby did not initialise");
   // software standby alone never disturbs stored values
   sw_standby_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      sw_standby && !hw_standby && !psel |=> $stable(dir_q) && $stable(latch_q))
      else $error("software standby changed registers");
   // read data mixes latch and pads by direction, as seen in the setup cycle
   latch_read_out_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == `SBP_ADDR_LATCH
      |=> prdata[6:0] == (($past(latch_q[6:0]) & $past(dir_q[6:0])) | ($past(pin_in) & ~$past(dir_q[6:0]))))
      else $error("port read mismatch");
   // two-wire clock owns pin six in both directions
   tw_overrides_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_r[`SBP_CTRL_TWE] |=> pin_oe[6] == $past(twclk_oe) && pin_out[6] == $past(twclk_out)
                                && twclk_in == $past(pin_in[6]))
      else $error("two-wire clock not owning pin");
   // slave mode with host control clear turns pin five into a select input
   host_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_r[`SBP_CTRL_SLV] && !ctrl_r[`SBP_CTRL_HPC] |=> !pin_oe[5] && host_sel_n == $past(pin_in[5]))
      else $error("host select not routed");
   // pin six level reaches interrupt line five
   ext_interrupt_line5_feed_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_r[`SBP_CTRL_IE5] |=> ext_ext_interrupt_line5_n == $past(pin_in[6]))
      else $error("interrupt five not fed");
   // read of the latch keeps bit seven set as well
   rsvd_read_one_a: assert property (@(posedge pclk) disable iff (!presetn)
      lat_read_s |=> prdata[7])
      else $error("reserved bit read as zero");
   // pins left to the port registers show latch and direction a cycle later
   latch_drives_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
      gpio_pins_s |=> pin_out == $past(latch_q[6:0]) && pin_oe == $past(dir_q[6:0]))
      else $error("pins do not follow latch");
   // input bits read the pad, even when a peripheral owns it
   input_read_pad_a: assert property (@(posedge pclk) disable iff (!presetn)
      lat_read_s |=> ((prdata[6:0] ^ $past(pin_in)) & ~$past(dir_q[6:0])) == 7'h00)
      else $error("input bit not read from pad");
   // latch takes the write whatever the direction
   latch_write_lands_a: assert property (@(posedge pclk) disable iff (!presetn)
      lat_write_s |=> latch_q[6:0] == $past(pwdata[6:0]))
      else $error("latch write lost");
   // external clock select makes pin six a serial clock input
   sck_input_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_r[`SBP_CTRL_TWE] && ctrl_r[`SBP_CTRL_XCK] |=> !pin_oe[6] && sck_in == $past(pin_in[6]))
      else $error("serial clock input not routed");
   // internal serial clock drives pin six
   sck_output_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_r[`SBP_CTRL_TWE] && !ctrl_r[`SBP_CTRL_XCK] && (ctrl_r[`SBP_CTRL_SYN] || ctrl_r[`SBP_CTRL_CKO])
      |=> pin_oe[6] && pin_out[6] == $past(sck_out))
      else $error("serial clock output not driven");
   // receive enable outside the host select case takes pin five
   rx_input_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(ctrl_r[`SBP_CTRL_SLV] && !ctrl_r[`SBP_CTRL_HPC]) && ctrl_r[`SBP_CTRL_REN]
      |=> !pin_oe[5] && rx_in == $past(pin_in[5]))
      else $error("receive input not routed");
   // pin five level reaches interrupt line four
   ext_interrupt_line4_feed_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_r[`SBP_CTRL_IE4] |=> ext_ext_interrupt_line4_n == $past(pin_in[5]))
      else $error("interrupt four not fed");
   // bus answer is a single-cycle pulse, never stretched
   ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready held longer than one cycle");
   // unmapped setup always ends in an error answer
   unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !hit |=> pready && pslverr)
      else $error("unmapped access not refused");
endmodule : sbp_port
`default_nettype wire

// >>> bench/sbp_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// far side of the pins: resolves each pad level from all drivers
module sbp_pin_model
(
   input  wire logic       pclk,
   input  wire logic [6:0] pin_out,
   input  wire logic [6:0] pin_oe,
   input  wire logic [6:0] ext_val,
   input  wire logic [6:0] ext_oe,
   output var  logic [6:0] pin_in
);
   logic [6:0] idle_r = 7'h2a;  // floating pads wander, so no stale level is ever read
   ////////////////////////////////////////////////////////////////////////
   // floating pattern flips every cycle
   always_ff @(posedge pclk)
   begin
      idle_r <= ~idle_r;
   end
   // outside driver wins a contention, which exposes latch read-back
   assign pin_in = (ext_oe & ext_val) | (~ext_oe & pin_oe & pin_out) | (~ext_oe & ~pin_oe & idle_r);
endmodule : sbp_pin_model
`default_nettype wire

// >>> bench/seven_bit_port_with_pin_mux_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbp_consts.svh"
module seven_bit_port_with_pin_mux_test;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        hw_standby, sw_standby, sck_out, twclk_out, twclk_oe;
   logic        twclk_in, sck_in, rx_in, host_sel_n, ext_ext_interrupt_line5_n, ext_ext_interrupt_line4_n;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [6:0]  pin_in, pin_out, pin_oe, ext_val, ext_oe;
   int          failures, comparisons, dv, lv, c, p6, p5, e6;
   sbp_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hw_standby(hw_standby), .sw_standby(sw_standby), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .sck_out(sck_out), .twclk_out(twclk_out), .twclk_oe(twclk_oe),
      .twclk_in(twclk_in), .sck_in(sck_in), .rx_in(rx_in), .host_sel_n(host_sel_n),
      .ext_ext_interrupt_line5_n(ext_ext_interrupt_line5_n), .ext_ext_interrupt_line4_n(ext_ext_interrupt_line4_n));
   sbp_pin_model u_pins (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
      .ext_oe(ext_oe), .pin_in(pin_in));
   ////////////////////////////////////////////////////////////////////////
   // 20 mhz clock
   initial
   begin
      pclk = 0;
      forever #25 pclk = ~pclk;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic complete_run();
      if (failures == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   // one apb transfer; holds the request until pready is seen high
   task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (n >= 16)
      begin
         failures++;
         $display("unexpected at %0t: no pready", $time);
         complete_run();
      end
      else
      begin
         rd = prdata;
         err = pslverr;
         psel <= 0; penable <= 0;
      end
   endtask : apb
   task automatic settle();
      repeat (3) @(posedge pclk);
      #1;
   endtask : settle
   // expected port read: latch where output, pad where input, bit 7 set
   function automatic logic [31:0] port_rd(int d, int l, logic [6:0] p);
      return 32'h80 | (l & d & 32'h7f) | ({25'h0, p} & ~d & 32'h7f);
   endfunction : port_rd
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      failures = 0; comparisons = 0; seed = 32'h1c35;
      presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      hw_standby = 0; sw_standby = 0; sck_out = 0; twclk_out = 0; twclk_oe = 0;
      ext_val = 7'h55; ext_oe = 7'h7f;
      repeat (3) @(posedge pclk);
      presetn <= 1;
      apb(0, `SBP_ADDR_DIR, 0); check(rd, 32'hff);
      apb(0, `SBP_ADDR_LATCH, 0); check(rd, port_rd(0, 0, ext_val));
      apb(0, 18'h0ff00, 0); check({err, rd[30:0]}, 32'h80000000);
      // random direction and latch, outside drivers fight every pad
      repeat (20)
      begin
         dv = rnd() & 32'hff; lv = rnd() & 32'h7f;
         ext_val <= 7'(rnd());
         apb(1, `SBP_ADDR_CTRL, 0);
         apb(1, `SBP_ADDR_LATCH, lv);
         apb(1, `SBP_ADDR_DIR, dv);
         apb(0, `SBP_ADDR_LATCH, 0); check(rd, port_rd(dv, lv, ext_val));
         apb(0, `SBP_ADDR_DIR, 0); check(rd, 32'hff);
         settle(); check({pin_oe, pin_out & dv[6:0]}, {dv[6:0], lv[6:0] & dv[6:0]});
      end
      // soft standby keeps everything, hard standby restores reset values
      sw_standby <= 1;
      settle(); check({pin_oe, pin_out & dv[6:0]}, {dv[6:0], lv[6:0] & dv[6:0]});
      apb(0, `SBP_ADDR_LATCH, 0); check(rd, port_rd(dv, lv, ext_val));
      sw_standby <= 0; hw_standby <= 1;
      settle(); hw_standby <= 0;
      settle(); check({25'h0, pin_oe}, 0);
      apb(1, `SBP_ADDR_DIR, 32'h7f);
      apb(0, `SBP_ADDR_LATCH, 0); check(rd, 32'h80);
      // pin function selection over random control words
      repeat (40)
      begin
         c = rnd() & 32'h1ff;
         ext_val <= 7'(rnd()); sck_out <= 1'(rnd()); twclk_out <= 1'(rnd()); twclk_oe <= 1'(rnd());
         apb(1, `SBP_ADDR_CTRL, c);
         p6 = c[0] ? 1 : c[1] ? 2 : (c[2] | c[3]) ? 3 : 0;
         p5 = (c[4] & !c[5]) ? 1 : c[6] ? 2 : 0;
         settle();
         apb(0, `SBP_ADDR_STATUS, 0); check(rd & 32'h3f, (p5 << 4) | (p6 << 2));
         check(twclk_in, p6 == 1 ? pin_in[6] : 1'b1);
         check(sck_in, p6 == 2 ? pin_in[6] : 1'b1);
         // pin six: bus clock, serial clock out, serial clock in, or direction one with latch zero
         e6 = (p6 == 1) ? {twclk_oe, twclk_out} : (p6 == 3) ? {1'b1, sck_out} : (p6 == 2) ? 0 : 2;
         check({pin_oe[6], pin_out[6]}, e6);
         check({pin_oe[5], pin_out[5]}, (p5 != 0) ? 0 : 2);
         check(host_sel_n, p5 == 1 ? pin_in[5] : 1'b1);
         check(rx_in, p5 == 2 ? pin_in[5] : 1'b1);
         check(ext_ext_interrupt_line5_n, c[7] ? pin_in[6] : 1'b1);
         check(ext_ext_interrupt_line4_n, c[8] ? pin_in[5] : 1'b1);
      end
      complete_run();
   end
endmodule : seven_bit_port_with_pin_mux_test
`default_nettype wire
